// >>> rtl/tsi2c_slave.sv
// two-wire slave port of a temperature sensor with pointer, limits, alarm
// Functional notes
// - answer to address 1001 followed by the three select pin levels.
// - select pins sampled all the time, never latched once.
// - the eight addresses run 0x48 to 0x4F by select pin value.
// - no SDA activity for the timeout drops the transfer, releases SDA.
// - start is SDA falling with SCL high; begins a new address byte.
// - after start, shift eight bits MSB first: address then direction.
// - on match, pull SDA low in the low phase before ninth pulse.
// - on mismatch, keep SDA released and ignore bytes until next start.
// - direction zero is master write, one is master read.
// - each byte is eight data pulses plus one receiver acknowledge.
// - SDA changes only while SCL low; SDA rising with SCL high is stop.
// - master not-acknowledges last read byte then stops; device stops driving.
// - direction fixed by address byte; switching needs a new start.
// - address plus one byte loads the pointer; reads use the pointer.
// - configuration write is pointer then one data byte.
// - limit write is pointer then two data bytes, high first.
// - pointer at configuration gives a one byte read.
// - temperature read returns high byte then low byte.
// - alarm starts in overtemperature mode, active at or above upper limit.
// - comparator behaviour selected after power-up until changed.
// - pointer low bits select register; pointer resets to zero.
// - comparator alarm holds until temperature drops below hysteresis.
// - interrupt alarm cleared by any read, rearms on reaching limit again.
`include "tsi2c_map.svh"

module tsi2c_slave
  import tsi2c_pkg::*;
#(
  parameter int TIMEOUT_US = `TSI_TIMEOUT_US,
  parameter int CLK_MHZ = `TSI_CLK_MHZ,
  parameter int BUF_DEPTH = `TSI_BUF_DEPTH
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic addr_select_bit2_pin_in,
  input wire logic addr_select_bit1_pin_in,
  input wire logic addr_select_bit0_pin_in,
  input wire logic [15:0] temp_value_in,
  output logic overtemp_alarm_output_out,
  output logic [7:0] config_out,
  output logic oneshot_start_out
);
  localparam int TO_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int TO_W = $clog2(TO_CYC + 1);

  if (TIMEOUT_US < 1 || CLK_MHZ < 1 || TO_CYC < 2) begin : g_bad_timeout
    $error("timeout must come to at least two clock cycles");
  end

  // ******************************************************************
  // pin synchronisers and edge detection
  // ******************************************************************
  logic scl_meta, scl_sync, scl_prev, sda_meta, sda_sync, sda_prev;
  logic [2:0] asel_meta, asel_sync;

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      {scl_meta, scl_sync, scl_prev} <= 3'h7;
      {sda_meta, sda_sync, sda_prev} <= 3'h7;
      asel_meta <= 3'h0;
      asel_sync <= 3'h0;
    end
    else
    begin
      {scl_meta, scl_sync, scl_prev} <= {scl_in, scl_meta, scl_sync};
      {sda_meta, sda_sync, sda_prev} <= {sda_in, sda_meta, sda_sync};
      // select pins tracked every cycle
      asel_meta <= {addr_select_bit2_pin_in, addr_select_bit1_pin_in,
                    addr_select_bit0_pin_in};
      asel_sync <= asel_meta;
    end
  end

  logic scl_rise, scl_fall, sda_edge, start_det, stop_det;
  logic [6:0] own_addr;
  assign scl_rise = scl_sync & ~scl_prev;
  assign scl_fall = ~scl_sync & scl_prev;
  assign sda_edge = sda_sync ^ sda_prev;
  assign start_det = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_det = scl_sync & scl_prev & ~sda_prev & sda_sync;
  assign own_addr = {`TSI_ADDR_HI, asel_sync};

  // ******************************************************************
  // bus engine
  // ******************************************************************
  tsi2c_state_t st_reg, st_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next, tx_reg, tx_next;
  logic [15:0] word_reg, word_next;
  logic [1:0] bidx_reg, bidx_next;
  logic rw_reg, rw_next, mack_reg, mack_next, oe_reg, oe_next;
  logic [TO_W-1:0] to_reg, to_next;
  logic to_hit, tx_load, rd_evt, push_valid, push_ready;
  logic [9:0] push_data;
  logic [7:0] ptr_reg, cfg_reg;
  logic [15:0] hyst_reg, tos_reg, sel_word;

  assign to_hit = (st_reg != ST_IDLE) && !sda_edge && (to_reg == TO_W'(TO_CYC - 1));

  always_comb
  begin
    case (ptr_reg[2:0])
      `TSI_PTR_TEMP: sel_word = temp_value_in;
      `TSI_PTR_CFG: sel_word = {cfg_reg, cfg_reg};
      `TSI_PTR_HYST: sel_word = hyst_reg;
      `TSI_PTR_TOS: sel_word = tos_reg;
      default: sel_word = {`TSI_RD_UNMAPPED, `TSI_RD_UNMAPPED};
    endcase
  end

  always_comb
  begin
    st_next = st_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    word_next = word_reg;
    bidx_next = bidx_reg;
    rw_next = rw_reg;
    mack_next = mack_reg;
    to_next = (st_reg == ST_IDLE || sda_edge) ? '0 : to_reg + 1'b1;
    tx_load = 1'b0;
    rd_evt = 1'b0;
    push_valid = 1'b0;
    push_data = {KIND_NONE, sh_reg};
    if (start_det)
    begin
      st_next = ST_ADDR;
      bit_next = '0;
      bidx_next = '0;
    end
    else if (stop_det || to_hit)
    begin
      st_next = ST_IDLE;
      bit_next = '0;
      bidx_next = '0;
    end
    else
    begin
      case (st_reg)
        ST_ADDR, ST_WDATA:
        begin
          if (scl_rise && bit_reg != `TSI_RX_LAST)
          begin
            sh_next = {sh_reg[6:0], sda_sync};
            bit_next = bit_reg + 1'b1;
          end
          else if (scl_fall && bit_reg == `TSI_RX_LAST)
          begin
            bit_next = '0;
            if (st_reg == ST_ADDR)
            begin
              rw_next = sh_reg[0];
              // mismatch goes quiet until the next start
              st_next = (sh_reg[7:1] == own_addr) ? ST_ACK_A : ST_IGNORE;
              rd_evt = (sh_reg[7:1] == own_addr) && sh_reg[0];
            end
            else
            begin
              push_valid = (bidx_reg != 2'(KIND_NONE));
              push_data = {bidx_reg, sh_reg};
              // full buffer: refuse the byte with a not-acknowledge
              st_next = (push_ready || !push_valid) ? ST_ACK_W : ST_IGNORE;
              if (bidx_reg != 2'(KIND_NONE))
                bidx_next = bidx_reg + 1'b1;
            end
          end
        end
        ST_ACK_A, ST_ACK_W:
        begin
          if (scl_fall)
          begin
            bit_next = '0;
            if (st_reg == ST_ACK_A && rw_reg)
            begin
              st_next = ST_RD;
              tx_load = 1'b1;
              word_next = sel_word; // snapshot keeps both halves coherent
              tx_next = sel_word[15:8];
              bidx_next = 2'h1;
            end
            else
              st_next = ST_WDATA;
          end
        end
        ST_RD:
        begin
          if (scl_fall)
          begin
            if (bit_reg == `TSI_TX_LAST)
              st_next = ST_RACK;
            else
            begin
              tx_next = {tx_reg[6:0], 1'b1};
              bit_next = bit_reg + 1'b1;
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            mack_next = ~sda_sync;
            if (sda_sync)
              st_next = ST_IGNORE;
          end
          else if (scl_fall && mack_reg)
          begin
            st_next = ST_RD;
            bit_next = '0;
            tx_load = 1'b1;
            // one byte register repeats; others alternate high, low
            tx_next = (ptr_reg[2:0] == `TSI_PTR_CFG || !bidx_reg[0]) ?
                      word_reg[15:8] : word_reg[7:0];
            bidx_next = bidx_reg + 1'b1;
          end
        end
        default: st_next = st_reg;
      endcase
    end
    oe_next = (st_next == ST_ACK_A) || (st_next == ST_ACK_W) ||
              ((st_next == ST_RD) && !tx_next[7]);
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_reg <= ST_IDLE;
      bit_reg <= '0;
      sh_reg <= '0;
      tx_reg <= '0;
      word_reg <= '0;
      bidx_reg <= '0;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
      oe_reg <= 1'b0;
      to_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      word_reg <= word_next;
      bidx_reg <= bidx_next;
      rw_reg <= rw_next;
      mack_reg <= mack_next;
      oe_reg <= oe_next;
      to_reg <= to_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = oe_reg;

  // ******************************************************************
  // received byte buffer and register file
  // ******************************************************************
  logic pop_valid, pop_ready, oneshot_reg, oneshot_next;
  logic [9:0] pop_data;
  logic [7:0] ptr_next, cfg_next, hi_reg, hi_next;
  logic [15:0] hyst_next, tos_next;

  // drain waits while a read snapshot is taken
  assign pop_ready = ~tx_load;

  tsi2c_buf #(.WIDTH(10), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .in_valid_in(push_valid),
    .in_ready_out(push_ready),
    .in_data_in(push_data),
    .out_valid_out(pop_valid),
    .out_ready_in(pop_ready),
    .out_data_out(pop_data)
  );

  always_comb
  begin
    ptr_next = ptr_reg;
    cfg_next = cfg_reg;
    hyst_next = hyst_reg;
    tos_next = tos_reg;
    hi_next = hi_reg;
    oneshot_next = 1'b0;
    if (pop_valid && pop_ready)
    begin
      case (pop_data[9:8])
        2'(KIND_PTR):
        begin
          ptr_next = pop_data[7:0];
          oneshot_next = (pop_data[2:0] == `TSI_PTR_ONESHOT);
        end
        2'(KIND_HI):
        begin
          hi_next = pop_data[7:0];
          if (ptr_reg[2:0] == `TSI_PTR_CFG)
            cfg_next = pop_data[7:0];
        end
        2'(KIND_LO):
        begin
          if (ptr_reg[2:0] == `TSI_PTR_HYST)
            hyst_next = {hi_reg, pop_data[7:0]};
          if (ptr_reg[2:0] == `TSI_PTR_TOS)
            tos_next = {hi_reg, pop_data[7:0]};
        end
        default: hi_next = hi_reg;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ptr_reg <= `TSI_PTR_RST;
      cfg_reg <= `TSI_CFG_RST;
      hyst_reg <= `TSI_HYST_RST;
      tos_reg <= `TSI_TOS_RST;
      hi_reg <= '0;
      oneshot_reg <= 1'b0;
    end
    else
    begin
      ptr_reg <= ptr_next;
      cfg_reg <= cfg_next;
      hyst_reg <= hyst_next;
      tos_reg <= tos_next;
      hi_reg <= hi_next;
      oneshot_reg <= oneshot_next;
    end
  end

  assign config_out = cfg_reg;
  assign oneshot_start_out = oneshot_reg;

  // ******************************************************************
  // overtemperature alarm
  // ******************************************************************
  logic hot, cool, act_reg, act_next, arm_reg, arm_next, pin_reg, pin_next;
  assign hot = $signed(temp_value_in) >= $signed(tos_reg);
  assign cool = $signed(temp_value_in) < $signed(hyst_reg);

  always_comb
  begin
    act_next = act_reg;
    arm_next = arm_reg;
    if (!cfg_reg[`TSI_CFG_INT_BIT])
    begin
      arm_next = 1'b1;
      if (hot)
        act_next = 1'b1;
      else if (cool)
        act_next = 1'b0;
    end
    else
    begin
      if (!hot)
        arm_next = 1'b1;
      if (hot && arm_reg)
      begin
        act_next = 1'b1;
        arm_next = 1'b0;
      end
      else if (rd_evt)
        act_next = 1'b0;
    end
    pin_next = cfg_reg[`TSI_CFG_POL_BIT] ? act_next : ~act_next;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      act_reg <= 1'b0;
      arm_reg <= 1'b1;
      pin_reg <= 1'b1;
    end
    else
    begin
      act_reg <= act_next;
      arm_reg <= arm_next;
      pin_reg <= pin_next;
    end
  end

  assign overtemp_alarm_output_out = pin_reg;

  // ******************************************************************
  // assertions
  // ******************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_start_new_addr: assert property (start_det |=> st_reg == ST_ADDR && bit_reg == 4'h0)
    else $error("start did not open an address byte");
  a_stop_release: assert property (stop_det |=> st_reg == ST_IDLE && !sda_oe_out)
    else $error("stop did not release the bus");
  a_ack_on_match: assert property (st_reg == ST_ADDR && scl_fall && bit_reg == `TSI_RX_LAST
      && sh_reg[7:1] == {`TSI_ADDR_HI, asel_sync} && !start_det && !stop_det && !to_hit
      |=> sda_oe_out && st_reg == ST_ACK_A)
    else $error("matched address not acknowledged");
  a_ignore_quiet: assert property (st_reg == ST_IGNORE |-> !sda_oe_out)
    else $error("sda driven while ignoring");
  a_timeout_drop: assert property (to_hit && !start_det && !stop_det
      |=> st_reg == ST_IDLE ##1 !sda_oe_out)
    else $error("timeout did not abandon transfer");
  a_nack_release: assert property (st_reg == ST_RACK && scl_rise && sda_sync
      && !start_det && !stop_det |=> !sda_oe_out [*2])
    else $error("still driving after not-acknowledge");
  a_rd_bit_drive: assert property (st_reg == ST_RD |-> sda_oe_out == !tx_reg[7])
    else $error("read data bit not on sda");
  a_ptr_load: assert property (pop_valid && pop_ready && pop_data[9:8] == 2'h0
      |=> ptr_reg == $past(pop_data[7:0]))
    else $error("pointer byte not loaded");
  a_cmp_alarm: assert property (!cfg_reg[`TSI_CFG_INT_BIT] && hot
      && !cfg_reg[`TSI_CFG_POL_BIT] ##1 !cfg_reg[`TSI_CFG_INT_BIT]
      && !cfg_reg[`TSI_CFG_POL_BIT] |-> !overtemp_alarm_output_out)
    else $error("comparator alarm not raised");
  a_int_clear: assert property (cfg_reg[`TSI_CFG_INT_BIT] && act_reg && rd_evt && !(hot && arm_reg)
      |=> !act_reg)
    else $error("read did not clear interrupt alarm");

  c_write_byte: cover property (push_valid && push_ready && push_data[9:8] == 2'h2);
  c_read_two: cover property (st_reg == ST_RACK && scl_fall && mack_reg);
  c_nomatch: cover property (st_reg == ST_ADDR ##1 st_reg == ST_IGNORE);
  c_timeout: cover property (to_hit);
endmodule : tsi2c_slave

// >>> pkg/tsi2c_map.svh
// constants: bus address, pointer codes, reset values, field positions
`ifndef TSI2C_MAP_SVH
`define TSI2C_MAP_SVH

`define TSI_ADDR_HI 4'h9
`define TSI_PTR_TEMP 3'h0
`define TSI_PTR_CFG 3'h1
`define TSI_PTR_HYST 3'h2
`define TSI_PTR_TOS 3'h3
`define TSI_PTR_ONESHOT 3'h4
`define TSI_PTR_RST 8'h00
`define TSI_CFG_RST 8'h00
`define TSI_HYST_RST 16'h4B00
`define TSI_TOS_RST 16'h5000
`define TSI_CFG_INT_BIT 1
`define TSI_CFG_POL_BIT 2
`define TSI_RD_UNMAPPED 8'h00
`define TSI_RX_LAST 4'h8
`define TSI_TX_LAST 4'h7
`define TSI_TIMEOUT_US 25000
`define TSI_CLK_MHZ 250
`define TSI_BUF_DEPTH 2

`endif

// >>> pkg/tsi2c_pkg.sv
// types shared by the temperature sensor serial port
package tsi2c_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK_A = 3'h2,
    ST_WDATA = 3'h3,
    ST_ACK_W = 3'h4,
    ST_RD = 3'h5,
    ST_RACK = 3'h6,
    ST_IGNORE = 3'h7
  } tsi2c_state_t;

  typedef enum logic [1:0] {
    KIND_PTR = 2'h0,
    KIND_HI = 2'h1,
    KIND_LO = 2'h2,
    KIND_NONE = 2'h3
  } tsi2c_kind_t;
endpackage : tsi2c_pkg

// >>> rtl/tsi2c_buf.sv
// small valid/ready buffer between byte receiver and register file
module tsi2c_buf #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("buffer depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready_out = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_reg != '0);
  assign out_data_out = mem_reg[rd_reg];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb
  begin
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (push)
    begin
      mem_next[wr_reg] = in_data_in;
      wr_next = wr_reg + 1'b1;
    end
    if (pop)
      rd_next = rd_reg + 1'b1;
    if (push && !pop)
      cnt_next = cnt_reg + 1'b1;
    else if (pop && !push)
      cnt_next = cnt_reg - 1'b1;
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= '0;
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      mem_reg <= mem_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule : tsi2c_buf

// >>> test/tsi2c_master_model.sv
// behavioural two-wire bus master facing the slave port
module tsi2c_master_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // quarter of a 160 ns bit period at 4 ns per cycle
  localparam int QTR = 10;

  initial
  begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask : idle

  // works from idle and as a repeated start from scl low
  task automatic start_cond();
    sda_oe_out <= 1'b0;
    idle(QTR);
    scl_out <= 1'b1;
    idle(QTR);
    sda_oe_out <= 1'b1;
    idle(QTR);
    scl_out <= 1'b0;
    idle(QTR);
  endtask : start_cond

  // data moves only while scl is low
  task automatic send_bit(input logic b);
    sda_oe_out <= !b;
    idle(QTR);
    scl_out <= 1'b1;
    idle(2 * QTR);
    scl_out <= 1'b0;
    idle(QTR);
  endtask : send_bit

  task automatic recv_bit(output logic b);
    sda_oe_out <= 1'b0;
    idle(QTR);
    scl_out <= 1'b1;
    idle(QTR);
    b = sda_in;
    idle(QTR);
    scl_out <= 1'b0;
    idle(QTR);
  endtask : recv_bit

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      send_bit(d[i]);
    recv_bit(b);
    ack = !b;
  endtask : write_byte

  // last high leaves the acknowledge slot released
  task automatic read_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--)
      recv_bit(d[i]);
    send_bit(last);
  endtask : read_byte

  task automatic stop_cond();
    sda_oe_out <= 1'b1;
    idle(QTR);
    scl_out <= 1'b1;
    idle(QTR);
    sda_oe_out <= 1'b0;
    idle(2 * QTR);
  endtask : stop_cond
endmodule : tsi2c_master_model

// >>> test/tsi2c_slave_tb_top.sv
// self-checking bench for the temperature sensor serial slave port
module tsi2c_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [2:0] sel; logic [6:0] addr; logic ack;} tsi2c_row_t;
  tsi2c_row_t rows[11] = '{
    '{3'h0, 7'h48, 1'b1}, '{3'h1, 7'h49, 1'b1}, '{3'h2, 7'h4A, 1'b1}, '{3'h3, 7'h4B, 1'b1},
    '{3'h4, 7'h4C, 1'b1}, '{3'h5, 7'h4D, 1'b1}, '{3'h6, 7'h4E, 1'b1}, '{3'h7, 7'h4F, 1'b1},
    '{3'h7, 7'h48, 1'b0}, '{3'h0, 7'h40, 1'b0}, '{3'h0, 7'h58, 1'b0}};
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [15:0] temp = 16'h1A50;
  logic scl, m_oe, sda, sda_oe, sda_drv, alarm, oneshot, a;
  logic [7:0] cfg;
  logic [7:0] d;
  logic [15:0] v;
  int fail_count = 0;
  int checks_done = 0;
  int os_count = 0;
  int n0;

  always #2 clk_in = ~clk_in;
  // open-drain wire with pull-up
  assign sda = !(sda_oe | m_oe);
  always @(posedge clk_in)
    if (oneshot === 1'b1)
      os_count <= os_count + 1;

  // shortened timeout: 2000 cycles, longer than any quiet sda stretch of a normal transfer
  tsi2c_slave #(.TIMEOUT_US(8)) dut (.clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_drv), .sda_oe_out(sda_oe), .addr_select_bit2_pin_in(sel[2]),
    .addr_select_bit1_pin_in(sel[1]), .addr_select_bit0_pin_in(sel[0]), .temp_value_in(temp),
    .overtemp_alarm_output_out(alarm), .config_out(cfg), .oneshot_start_out(oneshot));
  tsi2c_master_model bfm (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] ptr, input int n, input logic [15:0] val);
    bfm.start_cond();
    bfm.write_byte(8'h90, a);
    check(16'(a), 16'h0001, "address ack");
    bfm.write_byte(ptr, a);
    check(16'(a), 16'h0001, "pointer ack");
    if (n == 2)
    begin
      bfm.write_byte(val[15:8], a);
      check(16'(a), 16'h0001, "high byte ack");
    end
    if (n > 0)
    begin
      bfm.write_byte(val[7:0], a);
      check(16'(a), 16'h0001, "data byte ack");
    end
    bfm.stop_cond();
  endtask : wr

  task automatic rd(input int n, output logic [15:0] val);
    bfm.start_cond();
    bfm.write_byte(8'h91, a);
    check(16'(a), 16'h0001, "read address ack");
    val = 16'h0000;
    for (int i = n; i > 0; i--)
    begin
      bfm.read_byte(d, i == 1);
      val = {val[7:0], d};
    end
    check(16'(sda_oe), 16'h0000, "released after no acknowledge");
    bfm.stop_cond();
  endtask : rd

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    foreach (rows[i])
    begin
      sel <= rows[i].sel;
      repeat (5) @(posedge clk_in);
      bfm.start_cond();
      bfm.write_byte({rows[i].addr, 1'b0}, a);
      check(16'(a), 16'(rows[i].ack), "address match");
      bfm.write_byte(8'h00, a);
      check(16'(a), 16'(rows[i].ack), "byte after address");
      bfm.stop_cond();
    end
    sel <= 3'h0;
    check(16'(sda_drv), 16'h0000, "open-drain data level");
    wr(8'h01, 1, 16'h0018);
    check(16'(cfg), 16'h0018, "config stored");
    rd(1, v);
    check(v, 16'h0018, "config read");
    rd(1, v);
    check(v, 16'h0018, "pointer kept");
    // mid-run reset brings the defaults back
    rstn_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    check(16'(cfg), 16'h0000, "config reset");
    check(16'(alarm), 16'h0001, "alarm inactive in reset");
    rstn_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    rd(2, v);
    check(v, 16'h1A50, "temperature after pointer reset");
    wr(8'h03, 2, 16'h2340);
    rd(2, v);
    check(v, 16'h2340, "upper limit");
    wr(8'h02, 2, 16'h2000);
    rd(2, v);
    check(v, 16'h2000, "hysteresis limit");
    temp <= 16'h2340;
    repeat (3) @(posedge clk_in);
    check(16'(alarm), 16'h0000, "alarm at limit");
    temp <= 16'h2100;
    repeat (3) @(posedge clk_in);
    check(16'(alarm), 16'h0000, "alarm held above hysteresis");
    temp <= 16'h1F00;
    repeat (3) @(posedge clk_in);
    check(16'(alarm), 16'h0001, "alarm off below hysteresis");
    wr(8'h01, 1, 16'h0002);
    temp <= 16'h2400;
    repeat (3) @(posedge clk_in);
    check(16'(alarm), 16'h0000, "interrupt set");
    rd(1, v);
    check(16'(alarm), 16'h0001, "interrupt cleared by read");
    temp <= 16'h1000;
    repeat (3) @(posedge clk_in);
    temp <= 16'h2400;
    repeat (3) @(posedge clk_in);
    check(16'(alarm), 16'h0000, "interrupt rearmed");
    n0 = os_count;
    wr(8'h04, 0, 16'h0000);
    check(16'(os_count - n0), 16'h0001, "one-shot pulse");
    // device left holding sda low, then the master goes silent
    temp <= 16'h1A50;
    wr(8'h00, 0, 16'h0000);
    bfm.start_cond();
    bfm.write_byte(8'h91, a);
    check(16'(sda_oe), 16'h0001, "first read bit driven");
    bfm.idle(2100);
    check(16'(sda_oe), 16'h0000, "released on timeout");
    bfm.stop_cond();
    rd(2, v);
    check(v, 16'h1A50, "fresh start after timeout");
    // pointer write then repeated start into a read
    bfm.start_cond();
    bfm.write_byte(8'h90, a);
    bfm.write_byte(8'h01, a);
    bfm.start_cond();
    bfm.write_byte(8'h91, a);
    check(16'(a), 16'h0001, "ack after repeated start");
    bfm.read_byte(d, 1'b1);
    check(16'(d), 16'h0002, "read after repeated start");
    bfm.stop_cond();
    complete_run();
  end

  // whole run is near 27k cycles
  initial
  begin
    repeat (100000) @(posedge clk_in);
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule : tsi2c_slave_tb_top
